/* core/bivec_backplane.sv */
// backplane stage: own vectors or a bus acknowledge cycle
`timescale 1ns/1ps
`default_nettype none
module bivec_backplane
  import bivec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  bivec_ack_if.stage ack_if,
  input wire logic [7:0] back_base,
  input wire logic [7:1] back_req,
  input wire logic vme_grant,
  input wire logic vme_dtack,
  input wire logic [7:0] vme_data,
  output logic vme_bus_req_b,
  output logic vme_iack_b,
  output logic [2:0] vme_iack_level
);
  typedef enum logic [1:0] {BP_IDLE, BP_ARB, BP_CYCLE, BP_HOLD} bivec_bp_state_t;
  bivec_bp_state_t state_reg, state_next;
  logic [7:0] vector_reg, vector_next;
  logic valid_reg, valid_next, req_b_reg, req_b_next, iack_b_reg, iack_b_next;
  logic own_reg, own_next, fwd_reg, fwd_next;
  logic [2:0] level_reg, level_next;
  logic own_hit;

  assign own_hit = back_req[ack_if.level];
  assign ack_if.vector = vector_reg;
  assign ack_if.vec_valid = valid_reg;
  assign ack_if.own_evt = own_reg;
  assign ack_if.fwd_evt = fwd_reg;
  assign vme_bus_req_b = req_b_reg;
  assign vme_iack_b = iack_b_reg;
  assign vme_iack_level = level_reg;

  always_comb begin
    state_next = state_reg;
    vector_next = vector_reg;
    valid_next = valid_reg;
    req_b_next = req_b_reg;
    iack_b_next = iack_b_reg;
    level_next = level_reg;
    own_next = 1'b0;
    fwd_next = 1'b0;
    if (!ack_if.ack) begin
      // host ended the cycle: drop valid, release bus request and acknowledge; vector and level kept
      state_next = BP_IDLE;
      valid_next = 1'b0;
      req_b_next = 1'b1;
      iack_b_next = 1'b1;
    end else begin
      unique case (state_reg)
        BP_IDLE: begin
          level_next = ack_if.level;
          if (own_hit) begin
            vector_next = {back_base[7:BACK_BASE_LSB], ack_if.level};
            valid_next = 1'b1;
            own_next = 1'b1;
            state_next = BP_HOLD;
          end else if (vme_grant) begin
            iack_b_next = 1'b0;
            req_b_next = 1'b0;
            state_next = BP_CYCLE;
          end else begin
            req_b_next = 1'b0;
            state_next = BP_ARB;
          end
        end
        BP_ARB: begin
          if (vme_grant) begin
            iack_b_next = 1'b0;
            state_next = BP_CYCLE;
          end
        end
        BP_CYCLE: begin
          if (vme_dtack) begin
            vector_next = vme_data;
            valid_next = 1'b1;
            fwd_next = 1'b1;
            iack_b_next = 1'b1;
            state_next = BP_HOLD;
          end
        end
        BP_HOLD: state_next = BP_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= BP_IDLE;
      vector_reg <= 8'h00;
      valid_reg <= 1'b0;
      req_b_reg <= 1'b1;
      iack_b_reg <= 1'b1;
      level_reg <= 3'h0;
      own_reg <= 1'b0;
      fwd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      vector_reg <= vector_next;
      valid_reg <= valid_next;
      req_b_reg <= req_b_next;
      iack_b_reg <= iack_b_next;
      level_reg <= level_next;
      own_reg <= own_next;
      fwd_reg <= fwd_next;
    end
  end

  default clocking bp_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_own_pick;
    state_reg == BP_IDLE && ack_if.ack && own_hit;
  endsequence
  property p_own_vector;
    s_own_pick |=> valid_reg && vector_reg[2:0] == level_reg && own_reg;
  endproperty
  a_own_vector: assert property (p_own_vector) else $error("own vector wrong");
  property p_arbitrate;
    state_reg == BP_IDLE && ack_if.ack && !own_hit && !vme_grant
      |=> !req_b_reg && iack_b_reg && state_reg == BP_ARB;
  endproperty
  a_arbitrate: assert property (p_arbitrate) else $error("bus not requested");
  property p_hold_vector;
    valid_reg && ack_if.ack |=> valid_reg && $stable(vector_reg);
  endproperty
  a_hold_vector: assert property (p_hold_vector) else $error("vector not held");
endmodule
`default_nettype wire

/* core/bivec_top.sv */
// board interrupt acknowledge detection, priority chain and vectoring
// Operation
// - each interrupt source has its own software enable bit
// - every acknowledged pending source gets a status/id vector
// - acknowledge and its level decoded from address bus and function code
// - local controller drives its vector when requesting at acknowledged level
// - otherwise local controller passes acknowledge on to backplane stage
// - backplane stage returns own vector when requesting at that level
// - else backplane gets bus mastership and runs a bus acknowledge cycle
// - within a level: local, then backplane, then bus lines
// - local vector upper nibble from base bits 7..4, lower source code
// - peripheral local sources use codes 0011 through 1001
// - software ints use 1010 and 1011; serial vectors from serial chips
// - backplane vector: base bits 7..3 over level-equal three-bit code
// - abort switch raises level 7 only while enabled
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module bivec_top
  import bivec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cpu_as,
  input wire logic [2:0] cpu_fc,
  input wire logic [19:0] cpu_addr,
  output logic [2:0] cpu_ipl,
  output logic [7:0] cpu_vector,
  output logic cpu_vector_valid,
  input wire logic power_fail_irq,
  input wire logic bus_error_irq,
  input wire logic [6:0] periph_irq,
  input wire logic serial_irq,
  input wire logic [7:0] serial_vector,
  output logic serial_iack,
  input wire logic abort_sw_b,
  input wire logic [7:1] backplane_irq,
  input wire logic [7:1] vme_irq_b,
  input wire logic vme_grant_b,
  input wire logic vme_dtack_b,
  input wire logic [7:0] vme_data,
  output logic vme_bus_req_b,
  output logic vme_iack_b,
  output logic [2:0] vme_iack_level,
  output logic irq
);
  typedef enum logic [1:0] {CH_IDLE, CH_SERIAL, CH_PASS, CH_HOLD} bivec_chain_state_t;

  bivec_ack_if ack_if ();

  // pin synchronisers
  logic [SYNC_W-1:0] pin_raw, sync1_reg, sync2_reg, sync3_reg, pin_clean_reg, pin_clean_next;
  logic abort_prev_reg, abort_edge;
  assign pin_raw = {abort_sw_b, vme_dtack_b, vme_grant_b, vme_irq_b};
  assign pin_clean_next = (sync2_reg & sync3_reg) | (pin_clean_reg & (sync2_reg ^ sync3_reg));
  assign abort_edge = abort_prev_reg & ~pin_clean_reg[PIN_ABORT];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      pin_clean_reg <= '1;
      abort_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_clean_reg <= pin_clean_next;
      abort_prev_reg <= pin_clean_reg[PIN_ABORT];
    end
  end

  // register file
  logic [7:0] local_base_reg, back_base_reg;
  logic [EN_W-1:0] enable_reg;
  logic [29:0] level_reg;
  logic [1:0] swint_reg;
  logic [ST_W-1:0] status_reg, status_next, mask_reg, status_evt;
  logic [31:0] rdata_reg, rdata_next, state_view;
  logic irq_reg;
  logic wr_local_vec, wr_back_vec, wr_enable, wr_level, wr_swint, wr_status, wr_mask;
  assign wr_local_vec = reg_wr && reg_addr == LOCAL_VEC_ADDR;
  assign wr_back_vec = reg_wr && reg_addr == BACK_VEC_ADDR;
  assign wr_enable = reg_wr && reg_addr == ENABLE_ADDR;
  assign wr_level = reg_wr && reg_addr == LEVEL_ADDR;
  assign wr_swint = reg_wr && reg_addr == SWINT_ADDR;
  assign wr_status = reg_wr && reg_addr == STATUS_ADDR;
  assign wr_mask = reg_wr && reg_addr == MASK_ADDR;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      local_base_reg <= VEC_BASE_RESET;
      back_base_reg <= VEC_BASE_RESET;
      enable_reg <= ENABLE_RESET;
      level_reg <= LEVEL_RESET;
      swint_reg <= 2'h0;
      mask_reg <= MASK_RESET;
    end else begin
      if (wr_local_vec) local_base_reg <= reg_wdata[7:0];
      if (wr_back_vec) back_base_reg <= reg_wdata[7:0];
      if (wr_enable) enable_reg <= reg_wdata[EN_W-1:0];
      if (wr_level) level_reg <= reg_wdata[29:0];
      if (wr_swint) swint_reg <= reg_wdata[1:0];
      if (wr_mask) mask_reg <= reg_wdata[ST_W-1:0];
    end
  end

  // request gathering
  logic abort_pend_reg, abort_pend_next, abort_taken;
  logic [NUM_LOCAL-1:0] local_raw, local_req;
  logic [7:1] back_req, vme_req;
  logic [2:0] src_lvl [NUM_LOCAL];
  assign local_raw = {serial_irq, swint_reg, periph_irq, abort_pend_reg, bus_error_irq,
    power_fail_irq};
  assign local_req = local_raw & enable_reg[NUM_LOCAL-1:0];
  assign back_req = backplane_irq & enable_reg[EN_BACK_LSB +: 7];
  assign vme_req = ~pin_clean_reg[6:0] & enable_reg[EN_VME_LSB +: 7];
  // abort latches on press only while enabled; disabling drops it
  assign abort_pend_next = enable_reg[SRC_ABORT]
    & ((abort_edge) | (abort_pend_reg & ~abort_taken));

  for (genvar i = 0; i < NUM_LOCAL; i++) begin : g_lvl
    if (i < FIRST_PROG) begin : g_fixed
      assign src_lvl[i] = FIXED_LEVEL;
    end else begin : g_prog
      assign src_lvl[i] = level_reg[3*(i-FIRST_PROG) +: 3];
    end
  end

  // acknowledge decode
  logic iack_cycle;
  logic [2:0] iack_lvl;
  assign iack_cycle = cpu_as && cpu_fc == FC_CPU_SPACE && cpu_addr[19:16] == IACK_SPACE;
  assign iack_lvl = cpu_addr[3:1];

  // lowest index wins among local sources at the acknowledged level
  logic local_hit;
  logic [3:0] local_win;
  logic [2:0] ipl_next;
  always_comb begin
    local_hit = 1'b0;
    local_win = 4'h0;
    for (int i = NUM_LOCAL - 1; i >= 0; i--) begin
      if (local_req[i] && src_lvl[i] == iack_lvl) begin
        local_hit = 1'b1;
        local_win = 4'(i);
      end
    end
  end

  always_comb begin
    ipl_next = 3'h0;
    for (int i = 0; i < NUM_LOCAL; i++) begin
      if (local_req[i] && src_lvl[i] > ipl_next) ipl_next = src_lvl[i];
    end
    for (int j = 1; j <= 7; j++) begin
      if ((back_req[j] || vme_req[j]) && 3'(j) > ipl_next) ipl_next = 3'(j);
    end
  end

  // acknowledge chain
  bivec_chain_state_t state_reg, state_next;
  logic [7:0] vec_reg, vec_next, expect_local_vec;
  logic valid_reg, valid_next, ack_reg, ack_next, serial_reg, serial_next, local_taken;
  logic [2:0] lvl_reg, lvl_next, ipl_reg;
  assign expect_local_vec = {local_base_reg[LOCAL_BASE_LSB +: 4], local_win};
  assign abort_taken = state_reg == CH_IDLE && iack_cycle && local_hit
    && local_win == 4'(SRC_ABORT);

  always_comb begin
    state_next = state_reg;
    vec_next = vec_reg;
    valid_next = valid_reg;
    ack_next = ack_reg;
    serial_next = serial_reg;
    lvl_next = lvl_reg;
    local_taken = 1'b0;
    unique case (state_reg)
      CH_IDLE: begin
        if (iack_cycle) begin
          lvl_next = iack_lvl;
          if (local_hit && local_win == SRC_SERIAL) begin
            serial_next = 1'b1;
            state_next = CH_SERIAL;
          end else if (local_hit) begin
            vec_next = expect_local_vec;
            valid_next = 1'b1;
            local_taken = 1'b1;
            state_next = CH_HOLD;
          end else begin
            ack_next = 1'b1;
            state_next = CH_PASS;
          end
        end
      end
      CH_SERIAL: begin
        vec_next = serial_vector;
        valid_next = 1'b1;
        local_taken = 1'b1;
        state_next = CH_HOLD;
      end
      CH_PASS: begin
        if (!cpu_as) begin
          ack_next = 1'b0;
          state_next = CH_IDLE;
        end else if (ack_if.vec_valid) begin
          vec_next = ack_if.vector;
          valid_next = 1'b1;
          state_next = CH_HOLD;
        end
      end
      CH_HOLD: begin
        if (!cpu_as) begin
          valid_next = 1'b0;
          ack_next = 1'b0;
          serial_next = 1'b0;
          state_next = CH_IDLE;
        end
      end
    endcase
  end

  // interrupt status: set wins over the write-one clear
  assign status_evt = {ack_if.fwd_evt, ack_if.own_evt, local_taken,
    abort_edge & enable_reg[SRC_ABORT]};
  assign status_next = (status_reg & ~(wr_status ? reg_wdata[ST_W-1:0] : 4'h0)) | status_evt;
  assign state_view = {2'h0, vme_req, back_req, local_req, ipl_reg};
  assign rdata_next = !reg_rd ? 32'h0 :
    reg_addr == LOCAL_VEC_ADDR ? {24'h0, local_base_reg} :
    reg_addr == BACK_VEC_ADDR ? {24'h0, back_base_reg} :
    reg_addr == ENABLE_ADDR ? {5'h0, enable_reg} :
    reg_addr == LEVEL_ADDR ? {2'h0, level_reg} :
    reg_addr == SWINT_ADDR ? {30'h0, swint_reg} :
    reg_addr == STATUS_ADDR ? {28'h0, status_reg} :
    reg_addr == MASK_ADDR ? {28'h0, mask_reg} :
    reg_addr == STATE_ADDR ? state_view : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= CH_IDLE;
      vec_reg <= 8'h00;
      valid_reg <= 1'b0;
      ack_reg <= 1'b0;
      serial_reg <= 1'b0;
      lvl_reg <= 3'h0;
      ipl_reg <= 3'h0;
      abort_pend_reg <= 1'b0;
      status_reg <= 4'h0;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      vec_reg <= vec_next;
      valid_reg <= valid_next;
      ack_reg <= ack_next;
      serial_reg <= serial_next;
      lvl_reg <= lvl_next;
      ipl_reg <= ipl_next;
      abort_pend_reg <= abort_pend_next;
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
      rdata_reg <= rdata_next;
    end
  end

  assign ack_if.ack = ack_reg;
  assign ack_if.level = lvl_reg;

  bivec_backplane u_backplane (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ack_if(ack_if.stage),
    .back_base(back_base_reg),
    .back_req(back_req),
    .vme_grant(~pin_clean_reg[PIN_GRANT]),
    .vme_dtack(~pin_clean_reg[PIN_DTACK]),
    .vme_data(vme_data),
    .vme_bus_req_b(vme_bus_req_b),
    .vme_iack_b(vme_iack_b),
    .vme_iack_level(vme_iack_level)
  );

  assign reg_rdata = rdata_reg;
  assign cpu_ipl = ipl_reg;
  assign cpu_vector = vec_reg;
  assign cpu_vector_valid = valid_reg;
  assign serial_iack = serial_reg;
  assign irq = irq_reg;

  default clocking top_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_local_pick;
    state_reg == CH_IDLE && iack_cycle && local_hit && local_win != SRC_SERIAL;
  endsequence
  sequence s_serial_pick;
    state_reg == CH_IDLE && iack_cycle && local_hit && local_win == SRC_SERIAL;
  endsequence
  property p_local_vector;
    s_local_pick |=> valid_reg && vec_reg == $past(expect_local_vec);
  endproperty
  a_local_vector: assert property (p_local_vector) else $error("local vector wrong");
  property p_pass_on;
    state_reg == CH_IDLE && iack_cycle && !local_hit |=> ack_reg && !valid_reg;
  endproperty
  a_pass_on: assert property (p_pass_on) else $error("acknowledge not passed");
  property p_local_first;
    state_reg == CH_IDLE && iack_cycle && local_hit |=> !ack_reg [*2];
  endproperty
  a_local_first: assert property (p_local_first) else $error("local lost priority");
  property p_serial_vector;
    s_serial_pick |=> serial_reg && !valid_reg ##1 valid_reg && serial_reg;
  endproperty
  a_serial_vector: assert property (p_serial_vector) else $error("serial vector late");
  property p_fixed_level;
    local_req[SRC_POWER_FAIL] |=> ipl_reg == FIXED_LEVEL;
  endproperty
  a_fixed_level: assert property (p_fixed_level) else $error("level 7 not raised");
  property p_abort_gate;
    !enable_reg[SRC_ABORT] |=> !abort_pend_reg;
  endproperty
  a_abort_gate: assert property (p_abort_gate) else $error("disabled abort pending");
  property p_no_false_iack;
    state_reg == CH_IDLE && cpu_as && cpu_fc != FC_CPU_SPACE |=> state_reg == CH_IDLE;
  endproperty
  a_no_false_iack: assert property (p_no_false_iack) else $error("false acknowledge");
  property p_release;
    state_reg == CH_HOLD && !cpu_as |=> !valid_reg && !ack_reg && !serial_reg;
  endproperty
  a_release: assert property (p_release) else $error("vector not released");
endmodule
`default_nettype wire

/* shared/bivec_ack_if.sv */
// acknowledge hand-off between local controller and backplane stage
`timescale 1ns/1ps
`default_nettype none
interface bivec_ack_if;
  logic ack;
  logic [2:0] level;
  logic [7:0] vector;
  logic vec_valid;
  logic own_evt;
  logic fwd_evt;
  modport chain (output ack, output level, input vector, input vec_valid,
    input own_evt, input fwd_evt);
  modport stage (input ack, input level, output vector, output vec_valid,
    output own_evt, output fwd_evt);
endinterface
`default_nettype wire

/* shared/bivec_pkg.sv */
// constants of the board interrupt acknowledge and vector chain
package bivec_pkg;
  // register byte addresses
  localparam logic [31:0] LOCAL_VEC_ADDR = 32'hfffe102d;
  localparam logic [31:0] BACK_VEC_ADDR = 32'hfffe2013;
  localparam logic [31:0] ENABLE_ADDR = 32'hfffe1080;
  localparam logic [31:0] LEVEL_ADDR = 32'hfffe1084;
  localparam logic [31:0] SWINT_ADDR = 32'hfffe1088;
  localparam logic [31:0] STATUS_ADDR = 32'hfffe108c;
  localparam logic [31:0] MASK_ADDR = 32'hfffe1090;
  localparam logic [31:0] STATE_ADDR = 32'hfffe1094;
  // reset values
  localparam logic [7:0] VEC_BASE_RESET = 8'h0f;
  localparam logic [26:0] ENABLE_RESET = 27'h0000000;
  localparam logic [29:0] LEVEL_RESET = 30'h00000000;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // local source indices; the index is also the low vector code
  localparam int unsigned NUM_LOCAL = 13;
  localparam int unsigned SRC_POWER_FAIL = 0;
  localparam int unsigned SRC_BUS_ERROR = 1;
  localparam int unsigned SRC_ABORT = 2;
  localparam int unsigned FIRST_PROG = 3;
  localparam int unsigned SRC_SW1 = 10;
  localparam logic [3:0] SRC_SERIAL = 4'hc;
  localparam logic [2:0] FIXED_LEVEL = 3'h7;
  // enable register fields
  localparam int unsigned EN_W = 27;
  localparam int unsigned EN_BACK_LSB = 13;
  localparam int unsigned EN_VME_LSB = 20;
  // vector base fields
  localparam int unsigned LOCAL_BASE_LSB = 4;
  localparam int unsigned BACK_BASE_LSB = 3;
  // acknowledge decode
  localparam logic [2:0] FC_CPU_SPACE = 3'h7;
  localparam logic [3:0] IACK_SPACE = 4'hf;
  // status bits
  localparam int unsigned ST_W = 4;
  localparam int unsigned ST_ABORT = 0;
  localparam int unsigned ST_LOCAL = 1;
  localparam int unsigned ST_BACK = 2;
  localparam int unsigned ST_VME = 3;
  // synchronised pin bundle
  localparam int unsigned SYNC_W = 10;
  localparam int unsigned PIN_ABORT = 9;
  localparam int unsigned PIN_DTACK = 8;
  localparam int unsigned PIN_GRANT = 7;
endpackage

/* testbench/bivec_vme_slave.sv */
// bus-side partner: interrupting slave and bus arbiter
`timescale 1ns/1ps
`default_nettype none
module bivec_vme_slave (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] irq_level,
  input wire logic [7:0] vector,
  input wire logic [3:0] wait_cycles,
  input wire logic vme_bus_req_b,
  input wire logic vme_iack_b,
  input wire logic [2:0] vme_iack_level,
  output logic [7:1] vme_irq_b,
  output logic vme_grant_b,
  output logic vme_dtack_b,
  output logic [7:0] vme_data
);
  logic [7:0] irq_line;
  logic [1:0] grant_pipe;
  logic [3:0] wait_count;
  logic ack_match;
  // level 0 means no line pulled
  assign irq_line = ~(8'h01 << irq_level);
  assign vme_irq_b = irq_line[7:1];
  assign vme_grant_b = grant_pipe[1];
  assign ack_match = !vme_iack_b && vme_iack_level == irq_level && irq_level != 3'h0;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      grant_pipe <= 2'h3;
      wait_count <= 4'h0;
      vme_dtack_b <= 1'b1;
      vme_data <= 8'h00;
    end else begin
      grant_pipe <= {grant_pipe[0], vme_bus_req_b};
      if (ack_match) begin
        if (wait_count == wait_cycles) begin
          vme_dtack_b <= 1'b0;
          vme_data <= vector;
        end else begin
          wait_count <= wait_count + 4'h1;
        end
      end else begin
        wait_count <= 4'h0;
        vme_dtack_b <= 1'b1;
        // released lines invert the last vector every cycle
        vme_data <= ~vme_data;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/test_board_interrupt_ack_vectoring.sv */
// self-checking bench for the board interrupt acknowledge and vector chain
`timescale 1ns/1ps
`default_nettype none
module test_board_interrupt_ack_vectoring
  import bivec_pkg::*;
;
  logic clk_sys, rst_b, reg_wr, reg_rd, cpu_as, cpu_vector_valid, power_fail_irq;
  logic bus_error_irq, serial_irq;
  logic serial_iack, abort_sw_b, vme_grant_b, vme_dtack_b, vme_bus_req_b, vme_iack_b, irq;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, lv;
  logic [2:0] cpu_fc, cpu_ipl, vme_iack_level, slave_level;
  logic [19:0] cpu_addr;
  logic [7:0] cpu_vector, vme_data, serial_vector;
  logic [3:0] slave_wait;
  logic [6:0] periph_irq;
  logic [7:1] backplane_irq, vme_irq_b;
  int bad_count, comparisons, k;

  bivec_top u_bivec_top (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_as(cpu_as), .cpu_fc(cpu_fc), .cpu_addr(cpu_addr), .cpu_ipl(cpu_ipl),
    .cpu_vector(cpu_vector), .cpu_vector_valid(cpu_vector_valid),
    .power_fail_irq(power_fail_irq), .bus_error_irq(bus_error_irq), .periph_irq(periph_irq),
    .serial_irq(serial_irq), .serial_vector(serial_vector), .serial_iack(serial_iack),
    .abort_sw_b(abort_sw_b), .backplane_irq(backplane_irq), .vme_irq_b(vme_irq_b),
    .vme_grant_b(vme_grant_b), .vme_dtack_b(vme_dtack_b), .vme_data(vme_data),
    .vme_bus_req_b(vme_bus_req_b), .vme_iack_b(vme_iack_b),
    .vme_iack_level(vme_iack_level), .irq(irq));

  bivec_vme_slave u_bivec_vme_slave (.clk_sys(clk_sys), .rst_b(rst_b),
    .irq_level(slave_level), .vector(8'h5c), .wait_cycles(slave_wait),
    .vme_bus_req_b(vme_bus_req_b), .vme_iack_b(vme_iack_b),
    .vme_iack_level(vme_iack_level), .vme_irq_b(vme_irq_b), .vme_grant_b(vme_grant_b),
    .vme_dtack_b(vme_dtack_b), .vme_data(vme_data));

  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic settle(input logic [2:0] lvl);
    repeat (8) @(posedge clk_sys);
    #1;
    check(32'(cpu_ipl), 32'(lvl));
  endtask

  // host acknowledge cycle; vector must stand until the strobe drops
  task automatic iack(input logic [2:0] lvl, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    cpu_as <= 1'b1;
    cpu_fc <= FC_CPU_SPACE;
    cpu_addr <= {IACK_SPACE, 12'h000, lvl, 1'b0};
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cpu_vector_valid !== 1'b1 && n < 100);
    check(32'({cpu_vector_valid, cpu_vector}), {23'h0, 1'b1, exp});
    repeat (4) @(posedge clk_sys);
    #1;
    check(32'({cpu_vector_valid, cpu_vector}), {23'h0, 1'b1, exp});
    check(32'(serial_iack), 32'(serial_irq));
    @(posedge clk_sys);
    cpu_as <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic press();
    @(posedge clk_sys);
    abort_sw_b <= 1'b0;
    repeat (10) @(posedge clk_sys);
    abort_sw_b <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end

  initial begin
    bad_count = 0;
    comparisons = 0;
    rst_b = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_as = 1'b0;
    cpu_fc = 3'h0;
    cpu_addr = 20'h0;
    power_fail_irq = 1'b0;
    bus_error_irq = 1'b0;
    serial_irq = 1'b0;
    serial_vector = 8'h00;
    periph_irq = 7'h00;
    abort_sw_b = 1'b1;
    backplane_irq = 7'h00;
    slave_level = 3'h0;
    slave_wait = 4'h1;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(LOCAL_VEC_ADDR, 32'(VEC_BASE_RESET));
    rd(BACK_VEC_ADDR, 32'(VEC_BASE_RESET));
    rd(ENABLE_ADDR, 32'h0);
    rd(MASK_ADDR, 32'h0);
    wr(32'hfffe10f0, 32'hffffffff);
    rd(32'hfffe10f0, 32'h0);
    wr(LOCAL_VEC_ADDR, 32'ha5);
    wr(BACK_VEC_ADDR, 32'h58);
    rd(LOCAL_VEC_ADDR, 32'ha5);
    lv = 32'h0;
    for (k = 0; k < 10; k++) begin
      lv = lv | (32'h3 << (3 * k));
    end
    wr(LEVEL_ADDR, lv);
    wr(MASK_ADDR, 32'hf);
    periph_irq <= 7'h01;
    settle(3'h0);
    for (k = 3; k < 12; k++) begin
      wr(ENABLE_ADDR, 32'h1 << k);
      if (k < 10) begin
        periph_irq <= 7'h01 << (k - 3);
      end else begin
        wr(SWINT_ADDR, 32'h1 << (k - 10));
      end
      settle(3'h3);
      iack(3'h3, {4'ha, 4'(k)});
    end
    wr(SWINT_ADDR, 32'h0);
    periph_irq <= 7'h00;
    rd(STATUS_ADDR, 32'h2);
    check(32'(irq), 32'h1);
    wr(STATUS_ADDR, 32'hf);
    @(posedge clk_sys);
    #1;
    check(32'(irq), 32'h0);
    wr(MASK_ADDR, 32'h0);
    wr(ENABLE_ADDR, 32'h1);
    power_fail_irq <= 1'b1;
    settle(3'h7);
    iack(3'h7, 8'ha0);
    power_fail_irq <= 1'b0;
    check(32'(irq), 32'h0);
    wr(ENABLE_ADDR, (32'h1 << 3) | (32'h1 << 15));
    periph_irq <= 7'h01;
    backplane_irq <= 7'h04;
    settle(3'h3);
    iack(3'h3, 8'ha3);
    periph_irq <= 7'h00;
    iack(3'h3, 8'h5b);
    backplane_irq <= 7'h00;
    wr(ENABLE_ADDR, 32'h1 << 24);
    slave_level <= 3'h5;
    settle(3'h5);
    for (k = 0; k < 2; k++) begin
      slave_wait <= 4'(1 + 8 * k);
      iack(3'h5, 8'h5c);
      check(32'({vme_bus_req_b, vme_iack_b}), 32'h3);
    end
    rd(STATUS_ADDR, 32'he);
    slave_level <= 3'h0;
    wr(ENABLE_ADDR, 32'h0);
    press();
    settle(3'h0);
    rd(STATUS_ADDR, 32'he);
    wr(ENABLE_ADDR, 32'h4);
    press();
    settle(3'h7);
    iack(3'h7, 8'ha2);
    settle(3'h0);
    rd(STATUS_ADDR, 32'hf);
    wr(ENABLE_ADDR, 32'h2);
    bus_error_irq <= 1'b1;
    iack(3'h7, 8'ha1);
    bus_error_irq <= 1'b0;
    wr(ENABLE_ADDR, 32'h1 << 12);
    serial_irq <= 1'b1;
    serial_vector <= 8'h3c;
    iack(3'h3, 8'h3c);
    serial_irq <= 1'b0;
    @(posedge clk_sys);
    cpu_fc <= 3'h5;
    cpu_as <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cpu_as <= 1'b0;
    #1;
    check(32'({cpu_vector_valid, serial_iack, vme_bus_req_b}), 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
